// >>> src/amcc_axil.sv
// axi4-lite slave handshake front end for the register file
`timescale 1ns/10ps
module amcc_axil (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // axi4-lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // register file side
    output logic             wr_fire,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    logic aw_held;
    logic w_held;

    assign rd_addr = araddr;
    assign wr_fire = aw_held && w_held && !bvalid;

    // write address and data taken in either order
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held  <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
        end
    end

    // ready low while its half is held or the response waits
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            awready <= 1'b1;
            wready  <= 1'b1;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
            wready  <= 1'b1;
        end else begin
            awready <= awready && !awvalid;
            wready  <= wready && !wvalid;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp  <= 2'h0;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_err ? 2'h2 : 2'h0;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= 2'h0;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_err ? 32'h0000_0000 : rd_data;
            rresp   <= rd_err ? 2'h2 : 2'h0;
        end else if (rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end
endmodule

// >>> src/amcc_pkg.sv
// shared types of the asynchronous memory cycle block
package amcc_pkg;

    typedef enum logic [2:0] {
        AMCC_IDLE   = 3'b000,
        AMCC_TURN   = 3'b001,
        AMCC_SETUP  = 3'b010,
        AMCC_STROBE = 3'b011,
        AMCC_HOLD   = 3'b100
    } amcc_state_t;

    typedef struct packed {
        logic       ss;
        logic       ew;
        logic [3:0] setup;
        logic [5:0] strobe;
        logic [2:0] hold;
        logic [1:0] ta;
        logic       wide;
    } amcc_timing_t;

endpackage

// >>> src/amcc_regs.svh
// register offsets, field positions, reset values and beat counts
`ifndef AMCC_REGS_SVH
`define AMCC_REGS_SVH

`define AMCC_SPACE_CFG0_OFS   8'h00
`define AMCC_SPACE_CFG1_OFS   8'h04
`define AMCC_SPACE_CFG2_OFS   8'h08
`define AMCC_SPACE_CFG3_OFS   8'h0c
`define AMCC_WAIT_CFG_OFS     8'h10
`define AMCC_STATUS_OFS       8'h14

`define AMCC_SS_BIT           31
`define AMCC_EW_BIT           30
`define AMCC_W_SETUP_LSB      26
`define AMCC_W_STROBE_LSB     20
`define AMCC_W_HOLD_LSB       17
`define AMCC_R_SETUP_LSB      13
`define AMCC_R_STROBE_LSB     7
`define AMCC_R_HOLD_LSB       4
`define AMCC_TA_LSB           2
`define AMCC_BUS_WIDTH_SELECT_BIT        0

`define AMCC_SPACE_CFG_RST    32'h3fff_fffc
`define AMCC_WAIT_CFG_RST     32'h0000_0000

`define AMCC_BEATS_8BIT       3'h4
`define AMCC_BEATS_16BIT      3'h2

`endif

// >>> src/amcc_top.sv
// per-space configuration and external asynchronous memory cycle engine
`timescale 1ns/10ps
`include "amcc_regs.svh"
module amcc_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // axi4-lite register bus
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // system request port
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [1:0]  req_space,
    input  wire logic [22:0] req_word_addr,
    input  wire logic [31:0] req_wdata,
    output logic             resp_valid,
    output logic [31:0]      resp_rdata,
    // external memory pins
    output logic [3:0]       chip_enable_n,
    output logic             output_enable_n,
    output logic             write_enable_n,
    output logic             read_write_select,
    output logic [22:0]      ext_address,
    output logic [1:0]       ext_bank_address,
    input  wire logic [15:0] ext_data_in,
    output logic [15:0]      ext_data_out,
    output logic             ext_data_oe_n,
    input  wire logic [3:0]  wait_input
);
    logic [31:0]              space_config_reg [4];
    logic [31:0]              wait_cycle_config_reg;
    logic                     wr_fire;
    logic [7:0]               wr_addr;
    logic [31:0]              wr_data;
    logic [3:0]               wr_strb;
    logic [7:0]               rd_addr;
    logic [31:0]              rd_data;
    logic                     wr_err;
    logic                     rd_err;
    logic [3:0]               wait_meta;
    logic [3:0]               wait_sync;
    logic [15:0]              data_meta;
    logic [15:0]              data_sync;
    amcc_pkg::amcc_state_t    state;
    amcc_pkg::amcc_state_t    next_state;
    amcc_pkg::amcc_timing_t   tim;
    logic [5:0]               cnt;
    logic [5:0]               next_cnt;
    logic [2:0]               beat;
    logic [2:0]               next_beat;
    logic [2:0]               last_beat;
    logic                     cur_write;
    logic [1:0]               cur_space;
    logic [22:0]              cur_addr;
    logic [31:0]              cur_wdata;
    logic [31:0]              rd_acc;
    logic                     have_last;
    logic                     last_write;
    logic [1:0]               last_space;
    logic                     start;
    logic                     need_turn;
    logic                     stall;
    logic                     finish;
    logic                     beat_done;
    amcc_pkg::amcc_timing_t   new_tim;

    // --- register bus

    amcc_axil u_axil (
        .core_clk (core_clk),
        .nrst     (nrst),
        .awaddr   (awaddr),
        .awvalid  (awvalid),
        .awready  (awready),
        .wdata    (wdata),
        .wstrb    (wstrb),
        .wvalid   (wvalid),
        .wready   (wready),
        .bresp    (bresp),
        .bvalid   (bvalid),
        .bready   (bready),
        .araddr   (araddr),
        .arvalid  (arvalid),
        .arready  (arready),
        .rdata    (rdata),
        .rresp    (rresp),
        .rvalid   (rvalid),
        .rready   (rready),
        .wr_fire  (wr_fire),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .wr_strb  (wr_strb),
        .wr_err   (wr_err),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data),
        .rd_err   (rd_err)
    );

    // map a byte address to a register slot, 7 when unmapped
    function automatic logic [2:0] reg_slot(input logic [7:0] a);
        case (a)
            `AMCC_SPACE_CFG0_OFS: reg_slot = 3'h0;
            `AMCC_SPACE_CFG1_OFS: reg_slot = 3'h1;
            `AMCC_SPACE_CFG2_OFS: reg_slot = 3'h2;
            `AMCC_SPACE_CFG3_OFS: reg_slot = 3'h3;
            `AMCC_WAIT_CFG_OFS:   reg_slot = 3'h4;
            `AMCC_STATUS_OFS:     reg_slot = 3'h5;
            default:              reg_slot = 3'h7;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        merge = m;
    endfunction

    assign wr_err = reg_slot(wr_addr) > 3'h4;
    assign rd_err = reg_slot(rd_addr) == 3'h7;

    always_comb begin
        case (reg_slot(rd_addr))
            3'h0, 3'h1, 3'h2, 3'h3: rd_data = space_config_reg[rd_addr[3:2]];
            3'h4:    rd_data = {28'h0000000, wait_cycle_config_reg[3:0]};
            3'h5:    rd_data = {24'h000000, wait_sync, 1'b0, cur_space,
                                state != amcc_pkg::AMCC_IDLE};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    generate
        for (genvar s = 0; s < 4; s++) begin : g_space
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    space_config_reg[s] <= `AMCC_SPACE_CFG_RST;
                end else if (wr_fire && reg_slot(wr_addr) == 3'(s)) begin
                    space_config_reg[s] <= merge(space_config_reg[s], wr_data, wr_strb);
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wait_cycle_config_reg <= `AMCC_WAIT_CFG_RST;
        end else if (wr_fire && reg_slot(wr_addr) == 3'h4) begin
            wait_cycle_config_reg <= merge(wait_cycle_config_reg, wr_data, wr_strb);
        end
    end

    // --- pin synchronisers

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wait_meta <= 4'h0;
            wait_sync <= 4'h0;
            data_meta <= 16'h0000;
            data_sync <= 16'h0000;
        end else begin
            wait_meta <= wait_input;
            wait_sync <= wait_meta;
            data_meta <= ext_data_in;
            data_sync <= data_meta;
        end
    end

    // --- cycle engine

    // timing fields of one space for one direction
    always_comb begin
        new_tim.ss    = space_config_reg[req_space][`AMCC_SS_BIT];
        new_tim.ew    = space_config_reg[req_space][`AMCC_EW_BIT];
        new_tim.ta    = space_config_reg[req_space][`AMCC_TA_LSB +: 2];
        new_tim.wide  = space_config_reg[req_space][`AMCC_BUS_WIDTH_SELECT_BIT];
        if (req_write) begin
            new_tim.setup  = space_config_reg[req_space][`AMCC_W_SETUP_LSB +: 4];
            new_tim.strobe = space_config_reg[req_space][`AMCC_W_STROBE_LSB +: 6];
            new_tim.hold   = space_config_reg[req_space][`AMCC_W_HOLD_LSB +: 3];
        end else begin
            new_tim.setup  = space_config_reg[req_space][`AMCC_R_SETUP_LSB +: 4];
            new_tim.strobe = space_config_reg[req_space][`AMCC_R_STROBE_LSB +: 6];
            new_tim.hold   = space_config_reg[req_space][`AMCC_R_HOLD_LSB +: 3];
        end
    end

    assign start     = req_valid && req_ready;
    assign need_turn = have_last && (last_space != req_space || last_write != req_write);
    assign last_beat = tim.wide ? (`AMCC_BEATS_16BIT - 3'h1) : (`AMCC_BEATS_8BIT - 3'h1);
    assign stall     = tim.ew && (wait_sync[cur_space] == wait_cycle_config_reg[cur_space]);
    assign beat_done = state == amcc_pkg::AMCC_HOLD && cnt == 6'h00;
    assign finish    = beat_done && beat == last_beat;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_beat  = beat;
        case (state)
            amcc_pkg::AMCC_IDLE: begin
                if (start && need_turn) begin
                    next_state = amcc_pkg::AMCC_TURN;
                    next_cnt   = {4'h0, new_tim.ta};
                end else if (start) begin
                    next_state = amcc_pkg::AMCC_SETUP;
                    next_cnt   = {2'h0, new_tim.setup};
                end
                next_beat = 3'h0;
            end
            amcc_pkg::AMCC_TURN: begin
                if (cnt == 6'h00) begin
                    next_state = amcc_pkg::AMCC_SETUP;
                    next_cnt   = {2'h0, tim.setup};
                end else begin
                    next_cnt = cnt - 6'h01;
                end
            end
            amcc_pkg::AMCC_SETUP: begin
                if (cnt == 6'h00) begin
                    next_state = amcc_pkg::AMCC_STROBE;
                    next_cnt   = tim.strobe;
                end else begin
                    next_cnt = cnt - 6'h01;
                end
            end
            amcc_pkg::AMCC_STROBE: begin
                if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else if (!stall) begin
                    next_state = amcc_pkg::AMCC_HOLD;
                    next_cnt   = {3'h0, tim.hold};
                end
            end
            amcc_pkg::AMCC_HOLD: begin
                if (cnt != 6'h00) begin
                    next_cnt = cnt - 6'h01;
                end else if (beat == last_beat) begin
                    next_state = amcc_pkg::AMCC_IDLE;
                end else begin
                    next_state = amcc_pkg::AMCC_SETUP;
                    next_cnt   = {2'h0, tim.setup};
                    next_beat  = beat + 3'h1;
                end
            end
            default: begin
                next_state = amcc_pkg::AMCC_IDLE;
                next_cnt   = 6'h00;
                next_beat  = 3'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= amcc_pkg::AMCC_IDLE;
            cnt   <= 6'h00;
            beat  <= 3'h0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            beat  <= next_beat;
        end
    end

    // request snapshot, configuration sampled at start of each transfer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tim       <= '0;
            cur_write <= 1'b0;
            cur_space <= 2'h0;
            cur_addr  <= 23'h000000;
            cur_wdata <= 32'h0000_0000;
        end else if (start) begin
            tim       <= new_tim;
            cur_write <= req_write;
            cur_space <= req_space;
            cur_addr  <= req_word_addr;
            cur_wdata <= req_wdata;
        end
    end

    // history used by the turnaround decision
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            have_last  <= 1'b0;
            last_write <= 1'b0;
            last_space <= 2'h0;
        end else if (finish) begin
            have_last  <= 1'b1;
            last_write <= cur_write;
            last_space <= cur_space;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            req_ready <= 1'b1;
        end else if (start) begin
            req_ready <= 1'b0;
        end else if (finish) begin
            req_ready <= 1'b1;
        end
    end

    // read data gathered from the last strobe cycle of each beat
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_acc <= 32'h0000_0000;
        end else if (state == amcc_pkg::AMCC_STROBE && next_state == amcc_pkg::AMCC_HOLD) begin
            if (tim.wide) begin
                rd_acc[16*beat[0] +: 16] <= data_sync;
            end else begin
                rd_acc[8*beat[1:0] +: 8] <= data_sync[7:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            resp_valid <= 1'b0;
            resp_rdata <= 32'h0000_0000;
        end else begin
            resp_valid <= finish;
            if (finish && !cur_write) begin
                resp_rdata <= rd_acc;
            end
        end
    end

    // --- pins, registered from the next state
    logic n_active;
    logic n_strobe;
    logic n_wr;
    logic n_wide;
    logic [2:0] n_beat;
    logic n_ss;
    logic [1:0] n_space;
    logic [31:0] n_wdata;

    always_comb begin
        n_active = next_state == amcc_pkg::AMCC_SETUP ||
                   next_state == amcc_pkg::AMCC_STROBE ||
                   next_state == amcc_pkg::AMCC_HOLD;
        n_strobe = next_state == amcc_pkg::AMCC_STROBE;
        n_wr     = start ? req_write : cur_write;
        n_wide   = start ? new_tim.wide : tim.wide;
        n_beat   = next_beat;
        n_ss     = start ? new_tim.ss : tim.ss;
        n_space  = start ? req_space : cur_space;
        n_wdata  = start ? req_wdata : cur_wdata;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chip_enable_n <= 4'hf;
        end else begin
            chip_enable_n <= 4'hf;
            if (n_active && !n_ss) begin
                chip_enable_n[n_space] <= 1'b0;
            end else if (n_strobe && n_ss) begin
                chip_enable_n[n_space] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            output_enable_n   <= 1'b1;
            write_enable_n    <= 1'b1;
            read_write_select <= 1'b1;
        end else begin
            output_enable_n   <= !(n_strobe && !n_wr);
            write_enable_n    <= !(n_strobe && n_wr);
            read_write_select <= n_active ? !n_wr : 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_address      <= 23'h000000;
            ext_bank_address <= 2'h0;
        end else if (n_active) begin
            ext_address <= start ? req_word_addr : cur_addr;
            if (n_wide) begin
                ext_bank_address <= {n_beat[0], 1'b0};
            end else begin
                ext_bank_address <= n_beat[1:0];
            end
        end
    end

    // write data driven across setup, strobe and hold
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_data_out  <= 16'h0000;
            ext_data_oe_n <= 1'b1;
        end else begin
            ext_data_oe_n <= !(n_active && n_wr);
            if (n_active && n_wr) begin
                if (n_wide) begin
                    ext_data_out <= n_beat[0] ? n_wdata[31:16] : n_wdata[15:0];
                end else begin
                    ext_data_out <= {8'h00, n_wdata[8*n_beat[1:0] +: 8]};
                end
            end
        end
    end

endmodule

// >>> verif/amcc_mem.sv
// behavioural asynchronous memory with wait stalls
`timescale 1ns/10ps
module amcc_mem (
    // clock
    input wire logic        core_clk,
    // test control
    input wire logic [3:0]  wait_pol,
    input wire logic [3:0]  stall_len,
    // memory pins
    input wire logic        output_enable_n,
    input wire logic        write_enable_n,
    input wire logic [22:0] ext_address,
    input wire logic [1:0]  ext_bank_address,
    input wire logic [15:0] ext_data_out,
    input wire logic        ext_data_oe_n,
    output logic [15:0]     ext_data_in,
    output logic [3:0]      wait_input
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0;
    logic [3:0]  scnt = 4'h0;
    logic [3:0]  idx;
    assign idx = {ext_address[1:0], ext_bank_address};
    // released bus shows the inverse of the last value
    assign ext_data_in = output_enable_n ? ~last : mem[idx];
    // wait asserted for the first stall_len strobe cycles
    assign wait_input = (scnt < stall_len) ? wait_pol : ~wait_pol;
    always @(posedge core_clk) begin
        if (!output_enable_n) last <= mem[idx];
        if (!write_enable_n && !ext_data_oe_n) mem[idx] <= ext_data_out;
        scnt <= (output_enable_n && write_enable_n) ? 4'h0 : scnt + 4'h1;
    end
endmodule

// >>> verif/amcc_sva.sv
// concurrent checks on the external memory pins and request port
`timescale 1ns/10ps
module amcc_chk (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // request port
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        resp_valid,
    // memory pins
    input wire logic [3:0]  chip_enable_n,
    input wire logic        output_enable_n,
    input wire logic        write_enable_n,
    input wire logic        read_write_select,
    input wire logic [22:0] ext_address,
    input wire logic [1:0]  ext_bank_address,
    input wire logic [15:0] ext_data_out,
    input wire logic        ext_data_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    oe_read_a:
        assert property (!output_enable_n |-> read_write_select && write_enable_n)
        else $error("read strobe outside a read");
    we_write_a:
        assert property (!write_enable_n |-> !read_write_select && !ext_data_oe_n)
        else $error("write strobe without write select");
    strobe_cs_a:
        assert property (!(output_enable_n && write_enable_n) |-> chip_enable_n != 4'hf)
        else $error("strobe without chip enable");
    one_space_a:
        assert property ($countones(chip_enable_n) >= 3)
        else $error("two spaces enabled");
    setup_addr_a:
        assert property ($fell(output_enable_n && write_enable_n) |->
            $stable(ext_address) && $stable(ext_bank_address))
        else $error("address moved at strobe start");
    wdata_setup_a:
        assert property ($fell(write_enable_n) |-> $past(!ext_data_oe_n) && $stable(ext_data_out))
        else $error("write data not set up");
    wdata_lead_a:
        assert property ($fell(ext_data_oe_n) |=> $stable(ext_data_out))
        else $error("write data changed in setup");
    hold_addr_a:
        assert property ($rose(output_enable_n && write_enable_n) |->
            $stable(ext_address) && $stable(ext_bank_address))
        else $error("address moved at strobe end");
    wdata_hold_a:
        assert property ($rose(write_enable_n) |-> !ext_data_oe_n && $stable(ext_data_out))
        else $error("write data not held");
    req_done_a:
        assert property (req_valid && req_ready |-> ##[3:1000] resp_valid)
        else $error("request never completed");
    cover property (!write_enable_n);
    cover property (!output_enable_n);
    cover property (resp_valid);
endmodule

// >>> verif/tb_top.sv
// register and memory cycle tests
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_top;
    logic        core_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, req_valid = 0, req_write = 0, awready, wready, bvalid, arready;
    logic        rvalid, req_ready, resp_valid, output_enable_n, write_enable_n;
    logic        read_write_select, ext_data_oe_n;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, req_wdata = '0, rdata, resp_rdata, got, d;
    logic [3:0]  wstrb = 4'hf, chip_enable_n, wait_input, wpol = '0, slen = '0;
    logic [1:0]  req_space = '0, bresp, rresp, ext_bank_address;
    logic [22:0] req_word_addr = '0, ext_address;
    logic [15:0] ext_data_in, ext_data_out;
    int          fail_count = 0, tests_run = 0, strobes = 0, lowc = 0;
    amcc_top i_amcc_top (.*);
    amcc_mem i_amcc_mem (.wait_pol(wpol), .stall_len(slen), .*);
    initial forever #20 core_clk = ~core_clk;
    always @(negedge write_enable_n or negedge output_enable_n) strobes++;
    always @(posedge core_clk) if (!output_enable_n) lowc++;
    task automatic wrap_up;
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic to(input logic hit);
        if (hit) begin fail_count++; wrap_up(); end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n; logic aw, w, b; logic [1:0] r;
        @(posedge core_clk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 200; n++) begin
            @(negedge core_clk);
            aw = awready & awvalid; w = wready & wvalid; b = bvalid; r = bresp;
            @(posedge core_clk);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
            if (b) break;
        end
        bready <= 0; to(n == 200); `CHK("bresp", er, r)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n; logic ar, v; logic [31:0] x; logic [1:0] r;
        @(posedge core_clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 200; n++) begin
            @(negedge core_clk);
            ar = arready & arvalid; v = rvalid; x = rdata; r = rresp;
            @(posedge core_clk);
            if (ar) arvalid <= 0;
            if (v) break;
        end
        rready <= 0; to(n == 200); `CHK("rdata", e, x) `CHK("rresp", er, r)
    endtask
    task automatic req(input logic w, input int s, input logic [31:0] v);
        int n; logic t, k;
        @(posedge core_clk);
        req_valid <= 1; req_write <= w; req_space <= 2'(s); req_word_addr <= 23'(s);
        req_wdata <= v; strobes = 0; lowc = 0;
        for (n = 0; n < 2000; n++) begin
            @(negedge core_clk);
            t = req_ready & req_valid; k = resp_valid; got = resp_rdata;
            @(posedge core_clk);
            if (t) req_valid <= 0;
            if (k) break;
        end
        to(n == 2000);
    endtask
    function automatic logic [31:0] cf(input logic ss, ew, w);
        return {ss, ew, 4'h2, 6'h03, 3'h1, 4'h2, 6'h03, 3'h1, 2'h1, 1'b0, w};
    endfunction
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1;
        rd(8'h00, 32'h3fff_fffc, 2'h0);
        rd(8'h10, 32'h0, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h14, 32'h1, 2'h2);
        for (int i = 0; i < 4; i++) wr(8'(i * 4), cf(i[0], i[1], !i[0]), 2'h0);
        for (int i = 0; i < 4; i++) rd(8'(i * 4), cf(i[0], i[1], !i[0]), 2'h0);
        wr(8'h10, 32'h4, 2'h0);
        wpol <= 4'h4; slen <= 4'h6;
        for (int i = 0; i < 4; i++) begin
            d = 32'h1234_5678 + i;
            req(1'b1, i, d);
            `CHK("beats", i[0] ? 4 : 2, strobes)
            req(1'b0, i, 32'h0);
            `CHK("word", d, got)
            `CHK("strobe", 1'b1, i[1] ? lowc > 4 * strobes : lowc == 4 * strobes)
        end
        `CHK("half1", 16'h1234, i_amcc_mem.mem[2])
        `CHK("byte3", 8'h12, i_amcc_mem.mem[7][7:0])
        wr(8'h00, cf(1'b0, 1'b0, 1'b0), 2'h0);
        req(1'b1, 0, 32'h0);
        `CHK("beats", 4, strobes)
        wrap_up();
    end
endmodule
bind amcc_top amcc_chk i_amcc_chk (.core_clk, .nrst, .req_valid, .req_ready, .resp_valid,
    .chip_enable_n, .output_enable_n, .write_enable_n, .read_write_select, .ext_address,
    .ext_bank_address, .ext_data_out, .ext_data_oe_n);
